//--- sim/msg_sink.sv
// Downstream component model taking power limit messages
`timescale 1ns/1ps
`default_nettype none
module msg_sink (
	input wire logic	clock,
	input wire logic	rst_b,
	input wire logic	stall,
	input wire logic	msg_valid,
	input wire logic [7:0]	msg_value,
	input wire logic [1:0]	msg_scale,
	output logic		msg_ready,
	output logic [9:0]	last_msg,
	output logic [7:0]	got
);
	always_ff @(posedge clock or negedge rst_b)
		if (!rst_b) begin
			{msg_ready, last_msg, got} <= '0;
		end else begin
			msg_ready <= !stall;
			if (msg_valid && msg_ready) begin
				last_msg <= {msg_scale, msg_value};
				got <= got + 8'h01;
			end
		end
endmodule
`default_nettype wire

//--- sim/slot_cap_sva.sv
// Checker for slot capabilities reads and power limit messages
`timescale 1ns/1ps
`default_nettype none
module slot_cap_sva (
	input wire logic	clock,
	input wire logic	rst_b,
	input wire logic	hsel,
	input wire logic [31:0]	haddr,
	input wire logic [1:0]	htrans,
	input wire logic	hwrite,
	input wire logic [31:0]	hwdata,
	input wire logic	hready,
	input wire logic [31:0]	hrdata,
	input wire logic	load_valid,
	input wire logic [31:0]	load_data,
	input wire logic	link_dl_up,
	input wire logic	msg_valid,
	input wire logic	msg_ready,
	input wire logic [7:0]	msg_value,
	input wire logic [1:0]	msg_scale
);
	logic		wr_ff, rd_ff, si_ff, lk_ff;
	logic [7:0]	wa_ff;
	logic [31:0]	img_ff, exp_ff;
	wire		ap = hsel && hready && htrans[1];
	wire		w54 = wr_ff && wa_ff == 8'h54;
	wire [31:0]	view = si_ff ? img_ff & 32'hFFFBFFFC : 32'h0;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	// Shadow of stored fields, slot flag and lock
	always_ff @(posedge clock or negedge rst_b)
		if (!rst_b) begin
			{wr_ff, rd_ff, si_ff, lk_ff, wa_ff, img_ff, exp_ff} <= '0;
		end else begin
			wr_ff <= ap && hwrite;
			rd_ff <= ap && !hwrite && haddr[7:0] == 8'h54;
			wa_ff <= haddr[7:0];
			if (ap && !hwrite) exp_ff <= view;
			if (wr_ff && wa_ff == 8'h00 && !lk_ff) {si_ff, lk_ff} <= hwdata[1:0];
			if (load_valid) img_ff <= load_data;
			else if (w54 && si_ff) img_ff <= lk_ff ? {img_ff[31:17], hwdata[16:7], img_ff[6:0]} : hwdata;
		end
	a_read_view: assert property (rd_ff |-> hrdata == exp_ff)
		else $error("slot read wrong");
	a_dark_slot: assert property (rd_ff && !$past(si_ff) |-> hrdata == 32'h0)
		else $error("dark slot read not zero");
	a_no_cmpl: assert property (rd_ff |-> !hrdata[18])
		else $error("bit 18 set");
	a_ctrl_read: assert property (ap && !hwrite && haddr[7:0] == 8'h00 |=>
		hrdata[1] == $past(si_ff) && hrdata[0] == $past(lk_ff)) else $error("control read wrong");
	a_write_msg: assert property (ap && hwrite && haddr[7:0] == 8'h54 |-> ##2 msg_valid)
		else $error("no message after write");
	a_write_pay: assert property (w54 && !msg_valid && !load_valid |=>
		msg_valid && {msg_scale, msg_value} == img_ff[16:7]) else $error("write payload wrong");
	a_dlup_msg: assert property ($rose(link_dl_up) && !msg_valid && !load_valid && !w54 |=>
		msg_valid && {msg_scale, msg_value} == img_ff[16:7]) else $error("link up message wrong");
	a_msg_hold: assert property (msg_valid && !msg_ready |=>
		msg_valid && $stable(msg_value) && $stable(msg_scale)) else $error("message dropped");
endmodule
`default_nettype wire

//--- sim/tb_pcie_slot_capabilities_reg.sv
// Testbench for the slot capabilities register bank
`timescale 1ns/1ps
`default_nettype none
module tb_pcie_slot_capabilities_reg;
	logic		clock = 0, rst_b = 0, hsel = 0, hwrite = 0, load_valid = 0, link_dl_up = 0, stall = 0;
	logic [1:0]	htrans = 2'h0;
	logic [31:0]	haddr = 32'h0, hwdata = 32'h0, load_data = 32'h0, q;
	logic [9:0]	last_msg;
	logic [7:0]	got, n = 8'h0;
	wire		hreadyout, hresp, msg_valid, msg_ready;
	wire [31:0]	hrdata;
	wire [7:0]	msg_value;
	wire [1:0]	msg_scale;
	int		err_count = 0, total_checks = 0;
	logic [63:0]	rows [7] = '{{32'h4, 32'h4}, {32'h8, 32'h8}, {32'h10, 32'h10},
		{32'h20, 32'h20}, {32'h40, 32'h40}, {32'h20000, 32'h20000},
		{32'hFFFFFFFF, 32'hFFFBFFFC}};
	always #5 clock = ~clock;
	pcie_slot_capabilities_reg uut (.clock, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready(hreadyout), .hreadyout, .hresp, .hrdata, .load_valid, .load_data, .link_dl_up, .msg_valid,
		.msg_ready, .msg_value, .msg_scale);
	msg_sink far (.clock, .rst_b, .stall, .msg_valid, .msg_value, .msg_scale, .msg_ready, .last_msg, .got);
	task automatic cmp(input logic [31:0] e, input logic [31:0] a);
		total_checks++;
		if (a !== e) begin
			err_count++;
			$display("wrong value at %0t: expected %h got %h", $time, e, a);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'h1;
		hwrite <= w;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		@(posedge clock);
		while (hreadyout !== 1'h1) @(posedge clock);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clock);
		while (hreadyout !== 1'h1) @(posedge clock);
		q = hrdata;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		bus(1'h0, a, 32'h0);
		cmp(e, q);
		cmp(32'h0, {31'h0, hresp});
	endtask
	task automatic msg(input logic [9:0] e);
		while (got == n) @(posedge clock);
		n = got;
		cmp({22'h0, e}, {22'h0, last_msg});
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge clock);
		rst_b <= 1'h1;
		load_valid <= 1'h1;
		load_data <= 32'hFFFFFFFF;
		@(posedge clock);
		load_valid <= 1'h0;
		rd(8'h54, 32'h0);
		bus(1'h1, 8'h54, 32'h80);
		msg(10'h3FF);
		rd(8'h54, 32'h0);
		$display("dark slot test done");
		bus(1'h1, 8'h00, 32'h2);
		foreach (rows[i]) begin
			load_valid <= 1'h1;
			load_data <= rows[i][63:32];
			@(posedge clock);
			load_valid <= 1'h0;
			rd(8'h54, rows[i][31:0]);
		end
		$display("field table test done");
		for (int s = 0; s < 4; s++) begin
			bus(1'h1, 8'h54, {15'h0, s[1:0], 8'h5A, 7'h0});
			msg({s[1:0], 8'h5A});
			rd(8'h54, {15'h0, s[1:0], 8'h5A, 7'h0});
		end
		$display("scale test done");
		bus(1'h1, 8'h00, 32'h3);
		bus(1'h1, 8'h54, 32'hFFFFFFFF);
		msg(10'h3FF);
		rd(8'h54, 32'h1FF80);
		rd(8'h00, 32'h3);
		rd(8'h04, 32'h3FF);
		rd(8'h80, 32'h0);
		$display("lock test done");
		stall <= 1'h1;
		link_dl_up <= 1'h1;
		repeat (6) @(posedge clock);
		cmp(32'h0, {24'h0, got - n});
		stall <= 1'h0;
		msg(10'h3FF);
		$display("link up test done");
		complete_run();
	end
	initial begin
		#20000;
		err_count++;
		complete_run();
	end
endmodule
bind pcie_slot_capabilities_reg slot_cap_sva chk (.clock, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
	.hrdata, .load_valid, .load_data, .link_dl_up, .msg_valid, .msg_ready, .msg_value, .msg_scale);
`default_nettype wire

//--- src/pcie_slot_capabilities_reg.sv
// Slot capabilities register bank with power limit message trigger, AHB-Lite slave
//
// The register offsets and register access over AHB-Lite are this design's own decisions.
`include "slot_cap_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module pcie_slot_capabilities_reg #(
	parameter int SLOT_W = 13
) (
	input  wire logic        clock,
	input  wire logic        rst_b,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic        load_valid,
	input  wire logic [31:0] load_data,
	input  wire logic        link_dl_up,
	output logic             msg_valid,
	input  wire logic        msg_ready,
	output logic [7:0]       msg_value,
	output logic [1:0]       msg_scale
);
	logic [4:0]        flags_ff;
	logic [4:0]        nxt_flags;
	logic              ilock_ff;
	logic              nxt_ilock;
	logic [7:0]        plv_ff;
	logic [7:0]        nxt_plv;
	logic [1:0]        pls_ff;
	logic [1:0]        nxt_pls;
	logic [SLOT_W-1:0] slot_ff;
	logic [SLOT_W-1:0] nxt_slot;
	logic              lock_ff;
	logic              slot_impl_ff;
	logic              dl_up_ff;
	logic              pend_ff;
	logic              nxt_pend;
	logic              wr_ph_ff;
	logic [7:0]        wr_addr_ff;
	logic [31:0]       hrdata_ff;
	logic [31:0]       nxt_hrdata;
	logic [7:0]        msg_value_ff;
	logic [1:0]        msg_scale_ff;
	slot_cap_pkg::msg_state_t state_ff;
	slot_cap_pkg::msg_state_t nxt_state;

	function automatic logic is_cap(input logic [7:0] a);
		is_cap = (a == `SCAP_OFF_SLOT_CAP);
	endfunction

	wire        addr_ok   = hsel && hready && htrans[1];
	wire        rd_req    = addr_ok && !hwrite;
	wire        wr_req    = addr_ok && hwrite;
	wire [7:0]  a_addr    = haddr[7:0];
	wire        cap_wr    = wr_ph_ff && is_cap(wr_addr_ff);
	wire        ctrl_wr   = wr_ph_ff && (wr_addr_ff == `SCAP_OFF_CTRL);
	// Static fields accept bus writes only before lock
	wire        static_wr = cap_wr && slot_impl_ff && !lock_ff;
	wire        dyn_wr    = cap_wr && slot_impl_ff;
	wire        link_rise = link_dl_up && !dl_up_ff;
	// Any write of the register triggers, even when fields are gated
	wire        trigger   = cap_wr || link_rise;

	// Register view; everything gated by slot implemented, bit 18 zero
	wire [31:0] cap_view;
	assign cap_view[1:0] = 2'h0;
	generate
		for (genvar i = 0; i < 5; i++) begin : g_flag
			assign cap_view[`SCAP_BIT_LATCH + i] = slot_impl_ff & flags_ff[i];
		end
	endgenerate
	assign cap_view[`SCAP_PLV_HI:`SCAP_PLV_LO]   = slot_impl_ff ? plv_ff : 8'h00;
	assign cap_view[`SCAP_PLS_HI:`SCAP_PLS_LO]   = slot_impl_ff ? pls_ff : 2'h0;
	assign cap_view[`SCAP_BIT_ILOCK]             = slot_impl_ff & ilock_ff;
	assign cap_view[`SCAP_BIT_NOCMPL]            = 1'b0;
	assign cap_view[`SCAP_SLOT_HI:`SCAP_SLOT_LO] = slot_impl_ff ? slot_ff : '0;

	wire [31:0] ctrl_view = {30'h0, slot_impl_ff, lock_ff};
	wire [31:0] msg_view  = {pend_ff | (state_ff == slot_cap_pkg::MSG_SEND), 21'h0,
				 msg_scale_ff, msg_value_ff};

	always_comb begin
		nxt_hrdata = hrdata_ff;
		if (rd_req) begin
			if (is_cap(a_addr))
				nxt_hrdata = cap_view;
			else if (a_addr == `SCAP_OFF_CTRL)
				nxt_hrdata = ctrl_view;
			else if (a_addr == `SCAP_OFF_MSG)
				nxt_hrdata = msg_view;
			else
				nxt_hrdata = 32'h0000_0000;
		end
	end

	// Loader path overrides bus; both also write the power limit value and scale
	always_comb begin
		nxt_flags = flags_ff;
		nxt_ilock = ilock_ff;
		nxt_slot  = slot_ff;
		nxt_plv   = plv_ff;
		nxt_pls   = pls_ff;
		if (static_wr) begin
			nxt_flags = hwdata[`SCAP_BIT_HOTSW:`SCAP_BIT_LATCH];
			nxt_ilock = hwdata[`SCAP_BIT_ILOCK];
			nxt_slot  = hwdata[`SCAP_SLOT_HI:`SCAP_SLOT_LO];
		end
		if (dyn_wr) begin
			nxt_plv = hwdata[`SCAP_PLV_HI:`SCAP_PLV_LO];
			nxt_pls = hwdata[`SCAP_PLS_HI:`SCAP_PLS_LO];
		end
		if (load_valid) begin
			nxt_flags = load_data[`SCAP_BIT_HOTSW:`SCAP_BIT_LATCH];
			nxt_ilock = load_data[`SCAP_BIT_ILOCK];
			nxt_slot  = load_data[`SCAP_SLOT_HI:`SCAP_SLOT_LO];
			nxt_plv   = load_data[`SCAP_PLV_HI:`SCAP_PLV_LO];
			nxt_pls   = load_data[`SCAP_PLS_HI:`SCAP_PLS_LO];
		end
	end

	// Message: one pending request is remembered while a message is out
	always_comb begin
		nxt_state = state_ff;
		nxt_pend  = pend_ff;
		case (state_ff)
			slot_cap_pkg::MSG_IDLE: begin
				if (trigger || pend_ff) begin
					nxt_state = slot_cap_pkg::MSG_SEND;
					nxt_pend  = 1'b0;
				end
			end
			slot_cap_pkg::MSG_SEND: begin
				if (trigger)
					nxt_pend = 1'b1;
				if (msg_ready)
					nxt_state = slot_cap_pkg::MSG_IDLE;
			end
			default: nxt_state = slot_cap_pkg::MSG_IDLE;
		endcase
	end

	wire msg_load = (state_ff == slot_cap_pkg::MSG_IDLE) && (trigger || pend_ff);

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			flags_ff <= `SCAP_RST_FLAGS;
			ilock_ff <= 1'b0;
			plv_ff   <= `SCAP_RST_PLV;
			pls_ff   <= `SCAP_RST_PLS;
			slot_ff  <= '0;
		end else begin
			flags_ff <= nxt_flags;
			ilock_ff <= nxt_ilock;
			plv_ff   <= nxt_plv;
			pls_ff   <= nxt_pls;
			slot_ff  <= nxt_slot;
		end
	end

	// Lock is one-way until reset; slot implemented defaults clear
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			lock_ff      <= 1'b0;
			slot_impl_ff <= 1'b0;
		end else if (ctrl_wr) begin
			lock_ff      <= lock_ff | hwdata[`SCAP_CTRL_LOCK];
			slot_impl_ff <= lock_ff ? slot_impl_ff : hwdata[`SCAP_CTRL_SLOT];
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			wr_ph_ff   <= 1'b0;
			wr_addr_ff <= 8'h00;
			hrdata_ff  <= 32'h0000_0000;
			dl_up_ff   <= 1'b0;
		end else begin
			wr_ph_ff   <= wr_req;
			wr_addr_ff <= a_addr;
			hrdata_ff  <= nxt_hrdata;
			dl_up_ff   <= link_dl_up;
		end
	end

	// Message carries values as they stand after the triggering write
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			state_ff     <= slot_cap_pkg::MSG_IDLE;
			pend_ff      <= 1'b0;
			msg_value_ff <= 8'h00;
			msg_scale_ff <= 2'h0;
		end else begin
			state_ff <= nxt_state;
			pend_ff  <= nxt_pend;
			if (msg_load) begin
				msg_value_ff <= nxt_plv;
				msg_scale_ff <= nxt_pls;
			end
		end
	end

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_ff;
	assign msg_valid = (state_ff == slot_cap_pkg::MSG_SEND);
	assign msg_value = msg_value_ff;
	assign msg_scale = msg_scale_ff;
endmodule
`default_nettype wire

//--- src/slot_cap_cfg.svh
// Register offsets, field positions and reset values of the slot capabilities block
`ifndef SLOT_CAP_CFG_SVH
`define SLOT_CAP_CFG_SVH
`define SCAP_ADDR_W        8
`define SCAP_OFF_SLOT_CAP  8'h54
`define SCAP_OFF_CTRL      8'h00
`define SCAP_OFF_MSG       8'h04
`define SCAP_BIT_LATCH     2
`define SCAP_BIT_ATTN      3
`define SCAP_BIT_PWRL      4
`define SCAP_BIT_SURP      5
`define SCAP_BIT_HOTSW     6
`define SCAP_PLV_LO        7
`define SCAP_PLV_HI        14
`define SCAP_PLS_LO        15
`define SCAP_PLS_HI        16
`define SCAP_BIT_ILOCK     17
`define SCAP_BIT_NOCMPL    18
`define SCAP_SLOT_LO       19
`define SCAP_SLOT_HI       31
`define SCAP_CTRL_LOCK     0
`define SCAP_CTRL_SLOT     1
`define SCAP_MSG_VAL_LO    0
`define SCAP_MSG_SCL_LO    8
`define SCAP_MSG_BUSY      31
`define SCAP_RST_FLAGS     5'h00
`define SCAP_RST_PLV       8'h00
`define SCAP_RST_PLS       2'h0
`define SCAP_RST_SLOT      13'h0000
`define SCAP_SCALE_RSVD    2'h3
`endif

//--- src/slot_cap_pkg.sv
// Types shared by the slot capabilities block
package slot_cap_pkg;
	typedef enum logic [1:0] {
		SCALE_X1,
		SCALE_XP1,
		SCALE_XP01,
		SCALE_RSVD
	} power_scale_t;
	typedef enum logic [1:0] {
		AHB_IDLE,
		AHB_BUSY,
		AHB_NONSEQ,
		AHB_SEQ
	} htrans_t;
	typedef enum {
		MSG_IDLE,
		MSG_SEND
	} msg_state_t;
endpackage
